// ---- ptr_pkg.sv ----
// package: register map, field layout and reset values of the pulse template access block
package ptr_pkg;
  localparam logic [7:0] ADDR_PULSE_SCALE = 8'h06;
  localparam logic [7:0] ADDR_RAM_CONTROL = 8'h07;
  localparam logic [7:0] ADDR_RAM_DATA = 8'h08;
  localparam int TRIGGER_BIT = 7;
  localparam int DIRECTION_BIT = 6;
  localparam int INTERVAL_HI = 5;
  localparam int INTERVAL_LO = 4;
  localparam int SAMPLE_HI = 3;
  localparam int SAMPLE_LO = 0;
  localparam int AMPLITUDE_HI = 6;
  localparam int SCALE_HI = 5;
  localparam logic [5:0] SCALE_RESET = 6'h21;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [6:0] DATA_RESET = 7'h00;
  localparam logic [5:0] SCALE_T1_SHORT = 6'h36;
  localparam logic [5:0] SCALE_DS1_M7P5 = 6'h11;
  localparam logic [5:0] SCALE_DS1_M15 = 6'h08;
  localparam logic [5:0] SCALE_DS1_M22P5 = 6'h04;
  localparam logic [5:0] SCALE_E1 = 6'h21;
  localparam int RAM_DEPTH = 64;
  typedef enum logic [1:0] {
    PTR_IDLE = 2'b00,
    PTR_ACCESS = 2'b01,
    PTR_FINISH = 2'b11
  } ptr_state_type;
endpackage

// ---- ptr_template_ram.sv ----
// module: 64 x 7 pulse template memory, one synchronous port
`timescale 1ns/1ps
`default_nettype none
module ptr_template_ram (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [5:0] addr,
  input wire logic [6:0] wr_data,
  output logic [6:0] rd_data
);
  logic [6:0] mem_reg [0:ptr_pkg::RAM_DEPTH-1];

  // no reset on the array: contents are undefined until software loads them
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[addr] <= wr_data;
    end
    rd_data <= mem_reg[addr];
  end
endmodule
`default_nettype wire

// ---- ptr_pulse_template_access.sv ----
// module: transmit pulse scale register and indirect pulse template ram access
`timescale 1ns/1ps
`default_nettype none
module ptr_pulse_template_access (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [5:0] amplitude_scale,
  output logic access_busy
);
  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] scale_reg;
  logic trigger_reg;
  logic direction_reg;
  logic [1:0] interval_index_reg;
  logic [3:0] sample_index_reg;
  logic [6:0] sample_amplitude_reg;
  ptr_pkg::ptr_state_type state_reg;
  logic [6:0] ram_rd_data;
  logic ram_wr_en;
  logic [5:0] ram_addr;
  logic start_access;
  logic [7:0] rdata_next;

  assign start_access = reg_wr && reg_addr == ptr_pkg::ADDR_RAM_CONTROL
    && reg_wdata[ptr_pkg::TRIGGER_BIT] && state_reg == ptr_pkg::PTR_IDLE;
  // interval index forms the upper address bits, sample the lower
  assign ram_addr = {interval_index_reg, sample_index_reg};
  assign ram_wr_en = state_reg == ptr_pkg::PTR_ACCESS && !direction_reg;

  ptr_template_ram u_ram (
    .clk_sys(clk_sys),
    .wr_en(ram_wr_en),
    .addr(ram_addr),
    .wr_data(sample_amplitude_reg),
    .rd_data(ram_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scale only matters for user waveforms; the recommended values per template
  // (see package) are software's job, hardware just holds the step code
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scale_reg <= ptr_pkg::SCALE_RESET;
    end else if (reg_wr && reg_addr == ptr_pkg::ADDR_PULSE_SCALE) begin
      scale_reg <= reg_wdata[ptr_pkg::SCALE_HI:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      amplitude_scale <= ptr_pkg::SCALE_RESET;
    end else begin
      amplitude_scale <= scale_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and direction are frozen while an access runs so ram sees stable inputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      direction_reg <= ptr_pkg::CONTROL_RESET[ptr_pkg::DIRECTION_BIT];
      interval_index_reg <= ptr_pkg::CONTROL_RESET[ptr_pkg::INTERVAL_HI:ptr_pkg::INTERVAL_LO];
      sample_index_reg <= ptr_pkg::CONTROL_RESET[ptr_pkg::SAMPLE_HI:ptr_pkg::SAMPLE_LO];
    end else if (reg_wr && reg_addr == ptr_pkg::ADDR_RAM_CONTROL
        && state_reg == ptr_pkg::PTR_IDLE) begin
      direction_reg <= reg_wdata[ptr_pkg::DIRECTION_BIT];
      interval_index_reg <= reg_wdata[ptr_pkg::INTERVAL_HI:ptr_pkg::INTERVAL_LO];
      sample_index_reg <= reg_wdata[ptr_pkg::SAMPLE_HI:ptr_pkg::SAMPLE_LO];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ptr_pkg::PTR_IDLE;
    end else begin
      unique case (state_reg)
        ptr_pkg::PTR_IDLE: begin
          if (start_access) begin
            state_reg <= ptr_pkg::PTR_ACCESS;
          end
        end
        ptr_pkg::PTR_ACCESS: begin
          state_reg <= ptr_pkg::PTR_FINISH;
        end
        ptr_pkg::PTR_FINISH: begin
          state_reg <= ptr_pkg::PTR_IDLE;
        end
        default: begin
          state_reg <= ptr_pkg::PTR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      trigger_reg <= ptr_pkg::CONTROL_RESET[ptr_pkg::TRIGGER_BIT];
    end else if (start_access) begin
      trigger_reg <= 1'b1;
    end else if (state_reg == ptr_pkg::PTR_FINISH) begin
      trigger_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      access_busy <= 1'b0;
    end else begin
      access_busy <= start_access || (trigger_reg && state_reg != ptr_pkg::PTR_FINISH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writes to the data register during a read are dropped so the result is not torn
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sample_amplitude_reg <= ptr_pkg::DATA_RESET;
    end else if (state_reg == ptr_pkg::PTR_FINISH && direction_reg) begin
      sample_amplitude_reg <= ram_rd_data;
    end else if (reg_wr && reg_addr == ptr_pkg::ADDR_RAM_DATA
        && state_reg == ptr_pkg::PTR_IDLE) begin
      sample_amplitude_reg <= reg_wdata[ptr_pkg::AMPLITUDE_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      ptr_pkg::ADDR_PULSE_SCALE: rdata_next = {2'b00, scale_reg};
      ptr_pkg::ADDR_RAM_CONTROL: rdata_next = {trigger_reg, direction_reg,
        interval_index_reg, sample_index_reg};
      ptr_pkg::ADDR_RAM_DATA: rdata_next = {1'b0, sample_amplitude_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ---- ptr_access_chk.sv ----
// checker: timing and read-back properties of the pulse template access block
`timescale 1ns/1ps
`default_nettype none
module ptr_access_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] amplitude_scale,
  input wire logic access_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_scale_follow: assert property (reg_wr && reg_addr == 8'h06 |=> ##1
    amplitude_scale == $past(reg_wdata[5:0], 2)) else $error("scale not applied");
  a_busy_span: assert property (reg_wr && reg_addr == 8'h07 && reg_wdata[7]
    && !access_busy |=> access_busy [*2] ##1 !access_busy) else $error("access length wrong");
  a_busy_cause: assert property ($rose(access_busy) |->
    $past(reg_wr && reg_addr == 8'h07 && reg_wdata[7])) else $error("busy without trigger");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_scale_rsvd: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata[7:6] == 2'b00)
    else $error("scale reserved bits set");
  a_data_rsvd: assert property (reg_rd && reg_addr == 8'h08 |=> !reg_rdata[7])
    else $error("data reserved bit set");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h06 || reg_addr > 8'h08)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_trig_visible: assert property (reg_rd && reg_addr == 8'h07 && access_busy
    |=> reg_rdata[7]) else $error("trigger not seen while busy");
endmodule
bind ptr_pulse_template_access ptr_access_chk chk (.clk_sys, .sys_rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .amplitude_scale, .access_busy);
`default_nettype wire

// ---- pulse_template_ram_access_test.sv ----
// testbench: register and template memory checks against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module pulse_template_ram_access_test;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q;
  logic [5:0] amplitude_scale;
  logic access_busy;
  int failures = 0, cmp_count = 0, seed = 32'h06D7;
  logic [6:0] mem [64];
  logic [6:0] dat = 7'h00;
  logic [5:0] sc [5] = '{6'h36, 6'h11, 6'h08, 6'h04, 6'h21};
  always #5 clk_sys = ~clk_sys;
  ptr_pulse_template_access dut (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .amplitude_scale, .access_busy);
  ////////////////////////////////////////
  task automatic summarize;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys) #1 reg_wr = 0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, e);
    @(posedge clk_sys) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys) #1 reg_rd = 0;
    q = reg_rdata;
    chk(n, e, q);
  endtask
  // poll the trigger under a bound; the model only changes once the access is over
  task automatic wt(input logic [6:0] c);
    q = 8'hFF;
    for (int i = 0; i < 20 && q[7] !== 1'b0; i++) begin
      @(posedge clk_sys) #1 {reg_rd, reg_addr} = {1'b1, 8'h07};
      @(posedge clk_sys) #1 reg_rd = 0;
      q = reg_rdata;
    end
    if (q[7] !== 1'b0) begin
      failures++;
      summarize();
    end
    chk("control", {1'b0, c}, q);
    chk("busy", 8'h00, {7'h00, access_busy});
    if (c[6]) dat = mem[c[5:0]];
    else mem[c[5:0]] = dat;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 sys_rst = 0;
    chk("scale out", 8'h21, {2'b00, amplitude_scale});
    rc("scale", 8'h06, 8'h21);
    rc("control", 8'h07, 8'h00);
    rc("data", 8'h08, 8'h00);
    rc("unmapped", 8'h09, 8'h00);
    foreach (sc[i]) begin
      wr(8'h06, {2'b11, sc[i]});
      rc("scale", 8'h06, {2'b00, sc[i]});
      chk("scale out", {2'b00, sc[i]}, {2'b00, amplitude_scale});
    end
    // trigger bit low: only direction and address move, no access starts
    wr(8'h07, 8'h7A);
    rc("control", 8'h07, 8'h7A);
    chk("busy", 8'h00, {7'h00, access_busy});
    for (int a = 0; a < 64; a++) begin
      q = $random(seed);
      wr(8'h08, q);
      dat = q[6:0];
      rc("data", 8'h08, {1'b0, dat});
      wr(8'h07, {2'b10, a[5:0]});
      chk("busy", 8'h01, {7'h00, access_busy});
      wt({1'b0, a[5:0]});
    end
    for (int a = 63; a >= 0; a--) begin
      wr(8'h07, {2'b11, a[5:0]});
      wt({1'b1, a[5:0]});
      rc("data", 8'h08, {1'b0, dat});
    end
    // a data write one cycle after a write trigger lands while busy and must be dropped;
    // a write access leaves the data register alone, so a torn value would show here
    @(posedge clk_sys) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, 8'h07, 8'h85};
    @(posedge clk_sys) #1 {reg_addr, reg_wdata} = {8'h08, 1'b0, ~dat};
    @(posedge clk_sys) #1 reg_wr = 0;
    wt(7'h05);
    rc("data", 8'h08, {1'b0, dat});
    wr(8'h07, 8'hC5);
    wt(7'h45);
    rc("data", 8'h08, {1'b0, mem[5]});
    summarize();
  end
endmodule
`default_nettype wire
